// ===== stc_cfg.svh
// How it works
// RULE1: count packets dropped for lack of FIFO space
// RULE2: every missed packet pulses receiver overrun cause
// RULE3: counters hold while their direction is disabled
// RULE4: count extension errors, code 0x1F, gigabit only
// RULE5: length error below 64, above 1522/16384
// RULE6: lengths span destination address through CRC
// RULE7: pause receive counts global or station address
// RULE8: pause transmit counts queue or software cause
// RULE9: unsupported flow control: address, type match, bad opcode
// RULE10: good receive: clean, legal, filtered, not flow/missed
// RULE11: broadcast: clean, filtered, not missed
// RULE12: multicast: clean, filtered, not flow control
// RULE13: good transmit: clean, 64 bytes up, no flow
// RULE14: low read snapshots high half for next read
// RULE15: octet counters stick at all ones
// RULE16: good receive octets: clean, filtered, no flow
// RULE17: good transmit octets: 64 up, no flow
// RULE18: no buffer when head equals tail, non-flow
// RULE19: missed packets still feed total counters elsewhere
// RULE20: counters clear on read, stick at all ones
// RULE21: several counters step independently per packet
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define STC_OFF_MISSED     16'h4010
`define STC_OFF_CEXT       16'h403c
`define STC_OFF_LENERR     16'h4040
`define STC_OFF_PON_RX     16'h4048
`define STC_OFF_PON_TX     16'h404c
`define STC_OFF_POFF_RX    16'h4050
`define STC_OFF_POFF_TX    16'h4054
`define STC_OFF_FC_UNSUP   16'h4058
`define STC_OFF_GOOD_RX    16'h4074
`define STC_OFF_BCAST_RX   16'h4078
`define STC_OFF_MCAST_RX   16'h407c
`define STC_OFF_GOOD_TX    16'h4080
`define STC_OFF_ORX_LOW    16'h4088
`define STC_OFF_ORX_HIGH   16'h408c
`define STC_OFF_OTX_LOW    16'h4090
`define STC_OFF_OTX_HIGH   16'h4094
`define STC_OFF_NOBUF      16'h40a0
`define STC_OFF_CTRL       16'h4100

// ---------------------------------------------------------------
// counter slots, control fields, reset values
// ---------------------------------------------------------------
`define STC_NCNT           13
`define STC_IDX_MISSED     4'd0
`define STC_IDX_CEXT       4'd1
`define STC_IDX_LENERR     4'd2
`define STC_IDX_PON_RX     4'd3
`define STC_IDX_PON_TX     4'd4
`define STC_IDX_POFF_RX    4'd5
`define STC_IDX_POFF_TX    4'd6
`define STC_IDX_FC_UNSUP   4'd7
`define STC_IDX_GOOD_RX    4'd8
`define STC_IDX_BCAST_RX   4'd9
`define STC_IDX_MCAST_RX   4'd10
`define STC_IDX_GOOD_TX    4'd11
`define STC_IDX_NOBUF      4'd12
`define STC_CTRL_RX_EN     0
`define STC_CTRL_TX_EN     1
`define STC_CTRL_LPE       2
`define STC_CTRL_RESET     3'h0

// ---------------------------------------------------------------
// frame length limits and line codes
// ---------------------------------------------------------------
`define STC_LEN_MIN        16'h0040
`define STC_LEN_MAX_STD    16'h05f2
`define STC_LEN_MAX_LONG   16'h4000
`define STC_EXT_ERR_CODE   8'h1f

`endif

// ===== stc_pkg.sv
`include "stc_cfg.svh"

package stc_pkg;

	// whole state of the statistics block
	typedef struct packed {
		logic [`STC_NCNT-1:0][31:0] cnt;
		logic [63:0]                orx;
		logic [63:0]                otx;
		logic [31:0]                orx_snap;
		logic [31:0]                otx_snap;
		logic [2:0]                 ctrl;
		logic                       ext_seen;
		logic [7:0]                 rxd_s1;
		logic [7:0]                 rxd_s2;
		logic                       rx_er_s1;
		logic                       rx_er_s2;
		logic                       rx_ext_s1;
		logic                       rx_ext_s2;
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
		logic                       overrun;
	} stc_state_t;

endpackage

// ===== stc_counters.sv
`timescale 1ns/1ps
`include "stc_cfg.svh"

module stc_counters import stc_pkg::*; #(
	parameter int ADDR_W = 16,
	parameter int LEN_W  = 16
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// receive datapath, one pulse per packet
	input  wire logic              rx_pkt_valid,
	input  wire logic [LEN_W-1:0]  rx_pkt_len,
	input  wire logic              rx_filter_pass,
	input  wire logic              rx_no_error,
	input  wire logic              rx_fifo_full,
	input  wire logic              rx_is_bcast,
	input  wire logic              rx_is_mcast,
	input  wire logic              rx_fc_addr_match,
	input  wire logic              rx_fc_type_match,
	input  wire logic              rx_fc_opcode_ok,
	input  wire logic              rx_fc_pause_zero,
	input  wire logic              rx_desc_empty,
	input  wire logic              link_speed_1000,
	// receive pins from the phy
	input  wire logic [7:0]        gmii_rxd,
	input  wire logic              gmii_rx_er,
	input  wire logic              gmii_rx_ext,
	// transmit datapath, one pulse per packet
	input  wire logic              tx_pkt_valid,
	input  wire logic [LEN_W-1:0]  tx_pkt_len,
	input  wire logic              tx_no_error,
	input  wire logic              tx_is_pause,
	input  wire logic              tx_pause_zero,
	// interrupt cause
	output logic                   receiver_overrun_cause
);

	stc_state_t s;
	stc_state_t n;

	// ---------------------------------------------------------------
	// packet classification
	// ---------------------------------------------------------------
	logic [`STC_NCNT-1:0] inc;
	logic                 rx_en;
	logic                 tx_en;
	logic                 rx_go;
	logic                 tx_go;
	logic                 missed;
	logic                 fc_frame;
	logic                 fc_good;
	logic                 too_short;
	logic                 too_long;
	logic                 legal;
	logic                 ext_now;
	logic                 orx_add;
	logic                 otx_add;

	assign rx_en = s.ctrl[`STC_CTRL_RX_EN];
	assign tx_en = s.ctrl[`STC_CTRL_TX_EN];

	// direction enables gate every event, so disabled counters hold
	assign rx_go = rx_pkt_valid & rx_en;                                    // [RULE3]
	assign tx_go = tx_pkt_valid & tx_en;                                    // [RULE3]

	assign missed   = rx_go & rx_fifo_full;                                 // [RULE1]
	// missed only vetoes the good counts here; total counters outside still see it [RULE19]
	// a frame at either the reserved group or station address counts
	assign fc_frame = rx_fc_addr_match & rx_fc_type_match;                  // [RULE7]
	assign fc_good  = fc_frame & rx_fc_opcode_ok;

	// lengths arrive measured from destination address to last crc byte
	assign too_short = rx_pkt_len < `STC_LEN_MIN;                           // [RULE6]
	assign too_long  = s.ctrl[`STC_CTRL_LPE] ? (rx_pkt_len > `STC_LEN_MAX_LONG)
	                                         : (rx_pkt_len > `STC_LEN_MAX_STD); // [RULE5]
	assign legal     = !too_short && !too_long;

	// extension error seen on synchronised pins this cycle
	assign ext_now = rx_en && link_speed_1000 && s.rx_ext_s2 && s.rx_er_s2
	                 && (s.rxd_s2 == `STC_EXT_ERR_CODE);                    // [RULE4]

	// each counter decides on its own; one packet may step many
	always_comb begin                                                       // [RULE21]
		inc                    = '0;
		inc[`STC_IDX_MISSED]   = missed;                                    // [RULE1]
		inc[`STC_IDX_CEXT]     = rx_go && (s.ext_seen || ext_now);          // [RULE4]
		inc[`STC_IDX_LENERR]   = rx_go && rx_filter_pass && !legal;         // [RULE5]
		inc[`STC_IDX_PON_RX]   = rx_go && fc_good && rx_fc_pause_zero;      // [RULE7]
		inc[`STC_IDX_POFF_RX]  = rx_go && fc_good && !rx_fc_pause_zero;     // [RULE7]
		inc[`STC_IDX_PON_TX]   = tx_go && tx_is_pause && tx_pause_zero;     // [RULE8]
		inc[`STC_IDX_POFF_TX]  = tx_go && tx_is_pause && !tx_pause_zero;    // [RULE8]
		inc[`STC_IDX_FC_UNSUP] = rx_go && fc_frame && !rx_fc_opcode_ok;     // [RULE9]
		inc[`STC_IDX_GOOD_RX]  = rx_go && !missed && rx_no_error && legal
		                         && rx_filter_pass && !fc_frame;            // [RULE10]
		inc[`STC_IDX_BCAST_RX] = rx_go && !missed && rx_no_error
		                         && rx_filter_pass && rx_is_bcast;          // [RULE11]
		inc[`STC_IDX_MCAST_RX] = rx_go && !missed && rx_no_error
		                         && rx_filter_pass && rx_is_mcast && !fc_frame; // [RULE12]
		inc[`STC_IDX_GOOD_TX]  = tx_go && tx_no_error && !tx_is_pause
		                         && !(tx_pkt_len < `STC_LEN_MIN);           // [RULE13]
		inc[`STC_IDX_NOBUF]    = rx_go && rx_desc_empty && !fc_frame;       // [RULE18]
	end

	// receive octets drop the length check of the good receive count; transmit octets use the good transmit qualifiers
	assign orx_add = rx_go && !missed && rx_no_error && rx_filter_pass && !fc_frame; // [RULE16]
	assign otx_add = tx_go && tx_no_error && !tx_is_pause
	                 && !(tx_pkt_len < `STC_LEN_MIN);                       // [RULE17]

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	logic              setup;
	logic              rd_setup;
	logic              wr_access;
	logic [15:0]       addr16;
	logic              hit_cnt;
	logic [3:0]        hit_idx;
	logic              hit_other;

	assign setup     = psel && !penable;
	assign rd_setup  = setup && !pwrite;
	assign wr_access = psel && penable && s.pready && pwrite;
	assign addr16    = 16'(paddr);

	always_comb begin
		hit_cnt   = 1'b1;
		hit_idx   = `STC_IDX_MISSED;
		hit_other = 1'b0;
		case (addr16)
			`STC_OFF_MISSED:   hit_idx = `STC_IDX_MISSED;
			`STC_OFF_CEXT:     hit_idx = `STC_IDX_CEXT;
			`STC_OFF_LENERR:   hit_idx = `STC_IDX_LENERR;
			`STC_OFF_PON_RX:   hit_idx = `STC_IDX_PON_RX;
			`STC_OFF_PON_TX:   hit_idx = `STC_IDX_PON_TX;
			`STC_OFF_POFF_RX:  hit_idx = `STC_IDX_POFF_RX;
			`STC_OFF_POFF_TX:  hit_idx = `STC_IDX_POFF_TX;
			`STC_OFF_FC_UNSUP: hit_idx = `STC_IDX_FC_UNSUP;
			`STC_OFF_GOOD_RX:  hit_idx = `STC_IDX_GOOD_RX;
			`STC_OFF_BCAST_RX: hit_idx = `STC_IDX_BCAST_RX;
			`STC_OFF_MCAST_RX: hit_idx = `STC_IDX_MCAST_RX;
			`STC_OFF_GOOD_TX:  hit_idx = `STC_IDX_GOOD_TX;
			`STC_OFF_NOBUF:    hit_idx = `STC_IDX_NOBUF;
			`STC_OFF_ORX_LOW, `STC_OFF_ORX_HIGH, `STC_OFF_OTX_LOW,
			`STC_OFF_OTX_HIGH, `STC_OFF_CTRL: begin
				hit_cnt   = 1'b0;
				hit_other = 1'b1;
			end
			default:           hit_cnt = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// saturating helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] sat32(input logic [31:0] v);
		sat32 = (v == '1) ? v : v + 32'h1;                                  // [RULE20]
	endfunction

	function automatic logic [63:0] sat64(input logic [63:0] v, input logic [LEN_W-1:0] len);
		logic [64:0] sum;
		sum   = {1'b0, v} + 65'(len);
		sat64 = sum[64] ? '1 : sum[63:0];                                   // [RULE15]
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		n = s;

		// pins come from the phy clock, two flops before any use
		n.rxd_s1    = gmii_rxd;
		n.rxd_s2    = s.rxd_s1;
		n.rx_er_s1  = gmii_rx_er;
		n.rx_er_s2  = s.rx_er_s1;
		n.rx_ext_s1 = gmii_rx_ext;
		n.rx_ext_s2 = s.rx_ext_s1;

		// remember an extension error until its packet closes
		if (rx_pkt_valid)
			n.ext_seen = 1'b0;
		else if (ext_now)
			n.ext_seen = 1'b1;                                              // [RULE4]

		n.overrun = missed;                                                 // [RULE2]

		// counters step, saturating at all ones
		for (int i = 0; i < `STC_NCNT; i++) begin
			if (inc[i])
				n.cnt[i] = sat32(s.cnt[i]);                                 // [RULE20]
		end
		if (orx_add)
			n.orx = sat64(s.orx, rx_pkt_len);                               // [RULE16]
		if (otx_add)
			n.otx = sat64(s.otx, tx_pkt_len);                               // [RULE17]

		// apb: answer one cycle after setup, read data taken at setup
		n.pready  = setup;
		// error flag stands only beside its ready pulse, never lingers into idle
		n.pslverr = setup && !(hit_cnt || hit_other);
		if (setup)
			n.prdata = '0;

		// read side effects run at setup; an event in that cycle survives
		if (rd_setup && hit_cnt) begin
			n.prdata          = s.cnt[hit_idx];
			n.cnt[hit_idx]    = {31'h0, inc[hit_idx]};                      // [RULE20]
		end
		if (rd_setup) begin
			case (addr16)
				`STC_OFF_ORX_LOW: begin
					n.prdata   = s.orx[31:0];
					n.orx_snap = s.orx[63:32];                              // [RULE14]
					n.orx      = orx_add ? 64'(rx_pkt_len) : '0;            // [RULE20]
				end
				`STC_OFF_ORX_HIGH: n.prdata = s.orx_snap;                   // [RULE14]
				`STC_OFF_OTX_LOW: begin
					n.prdata   = s.otx[31:0];
					n.otx_snap = s.otx[63:32];                              // [RULE14]
					n.otx      = otx_add ? 64'(tx_pkt_len) : '0;            // [RULE20]
				end
				`STC_OFF_OTX_HIGH: n.prdata = s.otx_snap;                   // [RULE14]
				`STC_OFF_CTRL:     n.prdata = {29'h0, s.ctrl};
				default:           ;
			endcase
		end

		// control register write lands on the access edge
		if (wr_access && (addr16 == `STC_OFF_CTRL))
			n.ctrl = pwdata[2:0];
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s      <= '0;
			s.ctrl <= `STC_CTRL_RESET;
		end else begin
			s <= n;
		end
	end

	// outputs straight from flops
	assign prdata                 = s.prdata;
	assign pready                 = s.pready;
	assign pslverr                = s.pslverr;
	assign receiver_overrun_cause = s.overrun;

endmodule

// ===== stc_counters_monitor.sv
`timescale 1ns/1ps
module stc_counters_monitor (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// receive event and its cause
	input wire logic        rx_pkt_valid,
	input wire logic        rx_fifo_full,
	input wire logic        receiver_overrun_cause
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------------------------------
	// bus timing: no wait states
	// --------------------------------
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	access_ready_a: assert property (psel && penable |-> pready)
		else $error("access cycle without ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	err_data_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused read returns data");
	// read data only moves at a setup edge, so a slow master still sees it
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside setup");
	// --------------------------------
	// overrun cause follows a missed packet
	// --------------------------------
	overrun_cause_a: assert property (receiver_overrun_cause |-> $past(rx_pkt_valid && rx_fifo_full))
		else $error("overrun cause without missed packet");
	cover property (pslverr);
	cover property (receiver_overrun_cause);
	cover property (pready ##2 pready);
endmodule

bind stc_counters stc_counters_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pkt_valid(rx_pkt_valid),
	.rx_fifo_full(rx_fifo_full), .receiver_overrun_cause(receiver_overrun_cause));

// ===== stc_apb_host.sv
`timescale 1ns/1ps
module stc_apb_host (
	// clock
	input  wire logic        pclk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [15:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 16'h0;
		pwdata = 32'h0;
	end
	// one transfer; entered right after a rising edge, holds until ready
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic to);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		to = (n >= 50);
		q = prdata;
		e = pslverr;
		// released lines show junk so a slave cannot lean on stale values
		psel <= 0;
		penable <= 0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
endmodule

// ===== mac_statistics_counters_test.sv
`timescale 1ns/1ps
`include "stc_cfg.svh"
module mac_statistics_counters_test;
	logic pclk = 0, presetn = 0;
	wire logic psel, penable, pwrite, pready, pslverr, receiver_overrun_cause;
	wire logic [15:0] paddr;
	wire logic [31:0] pwdata, prdata;
	logic rx_pkt_valid = 0, rx_filter_pass = 0, rx_no_error = 0, rx_fifo_full = 0, rx_is_bcast = 0;
	logic rx_is_mcast = 0, rx_fc_addr_match = 0, rx_fc_type_match = 0, rx_fc_opcode_ok = 0;
	logic rx_fc_pause_zero = 0, rx_desc_empty = 0, link_speed_1000 = 0, gmii_rx_er = 0, gmii_rx_ext = 0;
	logic tx_pkt_valid = 0, tx_no_error = 0, tx_is_pause = 0, tx_pause_zero = 0;
	logic [15:0] rx_pkt_len = 0, tx_pkt_len = 0;
	logic [7:0]  gmii_rxd = 0;
	logic [63:0] m[13], orx, otx;
	logic [31:0] seed = 32'ha9c1;
	logic [15:0] offs[13] = '{`STC_OFF_MISSED, `STC_OFF_CEXT, `STC_OFF_LENERR, `STC_OFF_PON_RX, `STC_OFF_PON_TX,
		`STC_OFF_POFF_RX, `STC_OFF_POFF_TX, `STC_OFF_FC_UNSUP, `STC_OFF_GOOD_RX, `STC_OFF_BCAST_RX,
		`STC_OFF_MCAST_RX, `STC_OFF_GOOD_TX, `STC_OFF_NOBUF};
	logic [2:0]  ctab[6] = '{3'h3, 3'h0, 3'h7, 3'h1, 3'h2, 3'h7};
	int lt[8] = '{63, 64, 1522, 1523, 16384, 16385, 0, 1000};
	int fails = 0, n_compared = 0, cext = 0;

	always #25 pclk = ~pclk;

	stc_counters dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_pkt_valid, .rx_pkt_len, .rx_filter_pass, .rx_no_error, .rx_fifo_full, .rx_is_bcast, .rx_is_mcast,
		.rx_fc_addr_match, .rx_fc_type_match, .rx_fc_opcode_ok, .rx_fc_pause_zero, .rx_desc_empty,
		.link_speed_1000, .gmii_rxd, .gmii_rx_er, .gmii_rx_ext, .tx_pkt_valid, .tx_pkt_len, .tx_no_error,
		.tx_is_pause, .tx_pause_zero, .receiver_overrun_cause);
	stc_apb_host host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic summarize();
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("Error %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [31:0] x,
		input logic ex);
		logic [31:0] q;
		logic e, to;
		host_u.xfer(wr, a, d, q, e, to);
		if (to) begin
			fails++;
			summarize();
		end
		if (!wr) chk(q, x);
		chk({31'h0, e}, {31'h0, ex});
	endtask
	// drive one cycle of datapath traffic and step the reference counts
	task automatic pkt(input logic [2:0] c, output int ov);
		logic [31:0] r, t;
		int len, tl, mx;
		logic pz, lg, cl, fc;
		r = rnd();
		t = rnd();
		len = (r[16:14] == 3'd6) ? int'(r[30:20]) : lt[r[16:14]];
		tl = (t[6:4] == 3'd6) ? int'(t[30:20]) : lt[t[6:4]];
		{rx_pkt_valid, rx_filter_pass, rx_no_error, rx_fifo_full} <= {r[0], r[1], r[2] | r[12], r[3] & r[13]};
		{rx_fc_type_match, rx_fc_addr_match, rx_is_mcast, rx_is_bcast} <= r[7:4];
		{rx_desc_empty, rx_fc_pause_zero, rx_fc_opcode_ok} <= r[10:8];
		{tx_pkt_valid, tx_no_error, tx_is_pause, tx_pause_zero} <= {t[0], t[1] | t[2], t[3] & t[7], t[8]};
		rx_pkt_len <= 16'(len);
		tx_pkt_len <= 16'(tl);
		ov = r[0] & c[0] & r[3] & r[13];
		mx = c[2] ? 16384 : 1522;
		fc = r[6] & r[7];
		pz = r[6] & r[7] & r[8];
		lg = len >= 64 && len <= mx;
		cl = (r[2] | r[12]) & r[1] & !(r[3] & r[13]);
		if (r[0] && c[0]) begin
			m[0] += r[3] & r[13];
			m[1] += cext;
			cext = 0;
			m[2] += r[1] & !lg;
			m[3] += pz & r[9];
			m[5] += pz & !r[9];
			m[7] += r[6] & r[7] & !r[8];
			m[8] += cl & lg & !fc;
			m[9] += cl & r[4];
			m[10] += cl & r[5] & !fc;
			m[12] += r[10] & !fc;
			if (cl && !fc) orx += 64'(len);
		end
		if (t[0] && c[1]) begin
			lg = (t[1] | t[2]) && tl >= 64 && !(t[3] & t[7]);
			m[11] += lg;
			m[4] += t[3] & t[7] & t[8];
			m[6] += t[3] & t[7] & !t[8];
			if (lg) otx += 64'(tl);
		end
	endtask

	initial begin
		int ph, i, p1, p2;
		logic [2:0] c;
		for (i = 0; i < 13; i++) m[i] = 0;
		orx = 0;
		otx = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (i = 0; i < 13; i++) bus(0, offs[i], 0, 0, 0);
		for (ph = 0; ph < 6; ph++) begin
			c = ctab[ph];
			bus(1, `STC_OFF_CTRL, {29'h0, c}, 0, 0);
			bus(0, `STC_OFF_CTRL, 0, {29'h0, c}, 0);
			link_speed_1000 <= ph[0];
			// extension code only when receive is on, so no flag lingers into the next phase
			if (c[0]) begin
				{gmii_rxd, gmii_rx_er, gmii_rx_ext} <= {8'h1f, 2'b11};
				cext = ph[0];
			end
			repeat (4) @(posedge pclk);
			{gmii_rxd, gmii_rx_er, gmii_rx_ext} <= 10'h0;
			repeat (4) @(posedge pclk);
			p1 = 0;
			p2 = 0;
			for (i = 0; i < 42; i++) begin
				chk({31'h0, receiver_overrun_cause}, p2);
				p2 = p1;
				if (i < 40)
					pkt(c, p1);
				else begin
					{rx_pkt_valid, tx_pkt_valid} <= 2'b00;
					p1 = 0;
				end
				@(posedge pclk);
			end
			bus(1, offs[0], 32'h5, 0, 0);
			for (i = 0; i < 13; i++) begin
				bus(0, offs[i], 0, m[i][31:0], 0);
				m[i] = 0;
			end
			bus(0, `STC_OFF_ORX_LOW, 0, orx[31:0], 0);
			bus(0, `STC_OFF_ORX_HIGH, 0, orx[63:32], 0);
			bus(0, `STC_OFF_ORX_HIGH, 0, orx[63:32], 0);
			bus(0, `STC_OFF_OTX_LOW, 0, otx[31:0], 0);
			bus(0, `STC_OFF_OTX_HIGH, 0, otx[63:32], 0);
			orx = 0;
			otx = 0;
			bus(0, 16'h4004, 0, 0, 1);
		end
		summarize();
	end
endmodule
